// ==== mmap_pkg.sv ====
`default_nettype none
package mmap_pkg;
   localparam int LADDR_W = 16;
   localparam int GADDR_W = 18;
   localparam int PAGE_W = 4;
   localparam logic [3:0] PAGE_RESET = 4'hE;
   localparam logic [3:0] PAGE_FIXED_LOW = 4'hC;
   localparam logic [3:0] PAGE_FIXED_MID = 4'hD;
   localparam logic [3:0] PAGE_FIXED_TOP = 4'hF;
   localparam logic [15:0] DBG_WIN_LO = 16'hFF00;
   localparam logic [15:0] DBG_ALIAS_LO = 16'hBF00;
   localparam logic [17:0] REG_TOP = 18'h003FF;
   localparam logic [17:0] RAM_TOP = 18'h03FFF;
   localparam logic [17:0] DFLASH_LO = 18'h04400;
   localparam logic [17:0] DFLASH_TOP = 18'h053FF;
   localparam logic [17:0] PFLASH_TOP = 18'h3FFFF;
   localparam logic [15:0] PAGE_REG_ADDR = 16'h0015;
   localparam int STALL_LIMIT = 128;
   localparam int STALL_W = 8;

   typedef struct packed {
      logic req;
      logic wr;
      logic word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic req;
      logic wr;
      logic word;
      logic [17:0] addr;
      logic [15:0] wdata;
      logic dbg_sel;
   } tgt_req_s;

   typedef enum logic [1:0]
   {
      FAR_IDLE = 2'b00,
      FAR_SAVE = 2'b01,
      FAR_STACK = 2'b11,
      FAR_DONE = 2'b10
   } far_e;
endpackage : mmap_pkg
`default_nettype wire

// ==== addr_expand.sv ====
`default_nettype none
module addr_expand
   import mmap_pkg::*;
(
   input wire logic [15:0] laddr,
   input wire logic [3:0] page,
   input wire logic dbg_active,
   input wire logic dbg_cycle,
   input wire logic alias_ok,
   output logic [17:0] gaddr,
   output logic dbg_sel
);
   // window pages through the index, fixed blocks map to their own page
   always_comb
   begin
      unique case (laddr[15:14])
         2'b00: gaddr = {PAGE_FIXED_LOW, laddr[13:0]};
         2'b01: gaddr = {PAGE_FIXED_MID, laddr[13:0]};
         2'b10: gaddr = {page, laddr[13:0]};
         default: gaddr = {PAGE_FIXED_TOP, laddr[13:0]};
      endcase
   end

   // debug resources hide whatever shares their addresses
   assign dbg_sel = dbg_cycle
      | (dbg_active & (laddr >= DBG_WIN_LO))
      | (dbg_active & alias_ok & (page == PAGE_FIXED_TOP)
         & (laddr[15:8] == DBG_ALIAS_LO[15:8]));
endmodule : addr_expand
`default_nettype wire

// ==== unimpl_check.sv ====
`default_nettype none
module unimpl_check
   import mmap_pkg::*;
#(
   parameter logic [17:0] RAM_LOW = 18'h01400,
   parameter logic [17:0] PF_LOW = 18'h08000
)
(
   input wire logic [17:0] gaddr,
   output logic unimpl
);
   // each resource has a fixed top; sizes are set by the low bounds
   always_comb
   begin
      unimpl = 1'b1;
      if (gaddr <= REG_TOP)
         unimpl = 1'b0;
      else if (gaddr >= RAM_LOW && gaddr <= RAM_TOP)
         unimpl = 1'b0;
      else if (gaddr >= DFLASH_LO && gaddr <= DFLASH_TOP)
         unimpl = 1'b0;
      else if (gaddr >= PF_LOW && gaddr <= PFLASH_TOP)
         unimpl = 1'b0;
   end
endmodule : unimpl_check
`default_nettype wire

// ==== memory_map_paging_control.sv ====
`default_nettype none
// Summary of operation
// - debug resources enabled in debug read and write cycles and, in active debug, in the debug range
// - active debug maps debug tables and registers at 0xFF00-0xFFFF
// - resources overlapping debug range are hidden in active debug
// - active debug with page 0x0F also shows debug at 0xBF00-0xBFFF
// - page index selects a 16KB flash block in window 0x8000-0xBFFF
// - page index read and written by memory access and far call/return
// - local 0xC000-0xFFFF is unpaged
// - debug accesses expand with separate debug page index, 18 bits
// - debug page index used only when enabled and in commands
// - registers, SRAM, data flash, program flash on one target bus
// - processor access to unimplemented area in single chip, outside firmware commands, causes illegal access reset
// - debug access to unimplemented area completes, data undefined
// - master buses routed to target, processor read data byte swapped
// - one master per target; processor wins by default
// - debug stalled over 128 cycles takes bus after processor finishes
// - no interrupt requests raised
// - far call saves page, writes new, pushes return and page
// - indirect far call reads page via pointer, else immediate
// - far return pulls page, return address, then writes page index
// - far page writes complete before the instruction ends
// - page index resets to 0x0E
// - local 0xC000-0xFFFF maps to page 0x0F
// - local 0x4000-0x7FFF maps to page 0x0D
module memory_map_paging_control
   import mmap_pkg::*;
#(
   parameter logic [17:0] RAM_LOW = 18'h01400,
   parameter logic [17:0] PF_LOW = 18'h08000
)
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire mmap_pkg::bus_req_s cpu_req,
   input wire logic cpu_op_done,
   input wire logic cpu_fw_cmd,
   input wire logic cpu_single_chip,
   output logic cpu_stall,
   output logic [15:0] cpu_rdata,
   input wire mmap_pkg::bus_req_s dbg_req,
   input wire logic dbg_active,
   input wire logic dbg_read_cycle,
   input wire logic dbg_write_cycle,
   input wire logic dbg_page_en,
   input wire logic dbg_hw_cmd,
   input wire logic [3:0] debug_program_page_index,
   output logic dbg_grant,
   output logic [15:0] dbg_rdata,
   input wire logic far_call,
   input wire logic far_ret,
   input wire logic [3:0] far_page_new,
   output logic [3:0] far_page_saved,
   output logic far_busy,
   output mmap_pkg::tgt_req_s internal_target_bus,
   input wire logic [15:0] tgt_rdata,
   input wire logic tgt_ready,
   output logic [3:0] program_page_index,
   output logic illegal_access_reset,
   output logic irq
);
   logic [3:0] page_q;
   logic [3:0] page_d;
   logic [3:0] tmp_q;
   logic [3:0] tmp_d;
   far_e far_q;
   far_e far_d;
   logic is_call_q;
   logic is_call_d;
   logic [STALL_W-1:0] wait_q;
   logic [STALL_W-1:0] wait_d;
   logic dbg_own_q;
   logic dbg_own_d;
   logic [15:0] cpu_rdata_q;
   logic [15:0] cpu_rdata_d;
   logic [15:0] dbg_rdata_q;
   logic [15:0] dbg_rdata_d;
   logic ill_q;
   logic ill_d;
   logic [1:0] sc_sync_q;
   logic dbg_page_use;
   logic [3:0] dbg_page;
   logic [17:0] cpu_gaddr;
   logic [17:0] dbg_gaddr;
   logic cpu_dbg_sel;
   logic dbg_dbg_sel;
   logic cpu_unimpl;
   logic dbg_unimpl;
   logic cpu_page_hit;
   logic dbg_page_hit;
   logic cpu_go;
   logic dbg_go;

   function automatic logic [15:0] swap_bytes(input logic [15:0] d);
      swap_bytes = {d[7:0], d[15:8]};
   endfunction : swap_bytes

   function automatic logic page_reg_hit(input bus_req_s r);
      page_reg_hit = r.req & (r.addr == PAGE_REG_ADDR);
   endfunction : page_reg_hit

   // processor expansion; no debug cycle, only active debug qualifies debug resources
   addr_expand u_cpu_exp
   (
      .laddr(cpu_req.addr),
      .page(page_q),
      .dbg_active(dbg_active),
      .dbg_cycle(1'b0),
      .alias_ok(1'b1),
      .gaddr(cpu_gaddr),
      .dbg_sel(cpu_dbg_sel)
   );

   // debug page index only applies while enabled and a command runs
   assign dbg_page_use = dbg_page_en & (cpu_fw_cmd | dbg_hw_cmd);
   assign dbg_page = dbg_page_use ? debug_program_page_index : page_q;

   addr_expand u_dbg_exp
   (
      .laddr(dbg_req.addr),
      .page(dbg_page),
      .dbg_active(dbg_active),
      .dbg_cycle(dbg_read_cycle | dbg_write_cycle),
      .alias_ok(1'b1),
      .gaddr(dbg_gaddr),
      .dbg_sel(dbg_dbg_sel)
   );

   unimpl_check #(.RAM_LOW(RAM_LOW), .PF_LOW(PF_LOW)) u_cpu_chk
   (
      .gaddr(cpu_gaddr),
      .unimpl(cpu_unimpl)
   );

   unimpl_check #(.RAM_LOW(RAM_LOW), .PF_LOW(PF_LOW)) u_dbg_chk
   (
      .gaddr(dbg_gaddr),
      .unimpl(dbg_unimpl)
   );

   assign cpu_page_hit = page_reg_hit(cpu_req);
   assign dbg_page_hit = page_reg_hit(dbg_req);

   // arbitration: processor first, debug after a long wait
   always_comb
   begin
      wait_d = wait_q;
      dbg_own_d = dbg_own_q;
      if (!dbg_req.req)
      begin
         wait_d = '0;
         dbg_own_d = 1'b0;
      end
      else if (cpu_req.req && !dbg_own_q)
      begin
         if (wait_q != STALL_W'(STALL_LIMIT))
            wait_d = wait_q + 1'b1;
         // take over only once the processor ends its operation
         if (wait_q == STALL_W'(STALL_LIMIT) && cpu_op_done)
            dbg_own_d = 1'b1;
      end
   end

   // one master on the target bus at a time
   assign dbg_go = dbg_req.req & (dbg_own_q | !cpu_req.req);
   assign cpu_go = cpu_req.req & !dbg_go;
   assign cpu_stall = cpu_req.req & dbg_go;
   assign dbg_grant = dbg_go;
   assign far_busy = (far_q != FAR_IDLE);

   // master address and data steered onto the shared target bus
   always_comb
   begin
      internal_target_bus = '0;
      if (dbg_go)
      begin
         internal_target_bus.req = !dbg_page_hit;
         internal_target_bus.wr = dbg_req.wr;
         internal_target_bus.word = dbg_req.word;
         internal_target_bus.addr = dbg_gaddr;
         internal_target_bus.wdata = dbg_req.wdata;
         internal_target_bus.dbg_sel = dbg_dbg_sel;
      end
      else if (cpu_go)
      begin
         internal_target_bus.req = !cpu_page_hit & !(cpu_unimpl & !cpu_dbg_sel);
         internal_target_bus.wr = cpu_req.wr;
         internal_target_bus.word = cpu_req.word;
         internal_target_bus.addr = cpu_gaddr;
         internal_target_bus.wdata = cpu_req.wdata;
         internal_target_bus.dbg_sel = cpu_dbg_sel;
      end
   end

   // page index and far sequencing; far steps beat plain writes
   always_comb
   begin
      page_d = page_q;
      tmp_d = tmp_q;
      far_d = far_q;
      is_call_d = is_call_q;
      unique case (far_q)
         FAR_IDLE:
         begin
            if (far_call)
            begin
               tmp_d = page_q;
               page_d = far_page_new;
               is_call_d = 1'b1;
               far_d = FAR_SAVE;
            end
            else if (far_ret)
            begin
               tmp_d = far_page_new; // pulled page
               is_call_d = 1'b0;
               far_d = FAR_SAVE;
            end
            else if (cpu_go && cpu_page_hit && cpu_req.wr)
               page_d = cpu_req.wdata[3:0];
            else if (dbg_go && dbg_page_hit && dbg_req.wr)
               page_d = dbg_req.wdata[3:0];
         end
         FAR_SAVE: far_d = FAR_STACK; // return address step
         FAR_STACK:
         begin
            if (!is_call_q)
               page_d = tmp_q;
            far_d = FAR_DONE;
         end
         FAR_DONE: far_d = FAR_IDLE; // page settled before the end
      endcase
   end

   // read data: processor bytes swapped, unimplemented debug reads zero
   always_comb
   begin
      cpu_rdata_d = cpu_rdata_q;
      dbg_rdata_d = dbg_rdata_q;
      if (cpu_go && !cpu_req.wr)
         cpu_rdata_d = cpu_page_hit ? {12'h000, page_q} :
            swap_bytes(tgt_rdata);
      if (dbg_go && !dbg_req.wr)
         dbg_rdata_d = dbg_page_hit ? {12'h000, page_q} :
            (dbg_unimpl & !dbg_dbg_sel) ? 16'h0000 : tgt_rdata;
   end

   // illegal access only for processor in single chip, not firmware
   assign ill_d = cpu_go & cpu_unimpl & !cpu_dbg_sel & !cpu_page_hit
      & sc_sync_q[1] & !cpu_fw_cmd & tgt_ready;

   // mode level from outside this clock is synchronised first
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         sc_sync_q <= 2'b00;
      else
         sc_sync_q <= {sc_sync_q[0], cpu_single_chip};
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         page_q <= PAGE_RESET;
         tmp_q <= 4'h0;
         far_q <= FAR_IDLE;
         is_call_q <= 1'b0;
         wait_q <= '0;
         dbg_own_q <= 1'b0;
         cpu_rdata_q <= 16'h0000;
         dbg_rdata_q <= 16'h0000;
         ill_q <= 1'b0;
      end
      else
      begin
         page_q <= page_d;
         tmp_q <= tmp_d;
         far_q <= far_d;
         is_call_q <= is_call_d;
         wait_q <= wait_d;
         dbg_own_q <= dbg_own_d;
         cpu_rdata_q <= cpu_rdata_d;
         dbg_rdata_q <= dbg_rdata_d;
         ill_q <= ill_d;
      end
   end

   assign program_page_index = page_q;
   assign far_page_saved = tmp_q;
   assign cpu_rdata = cpu_rdata_q;
   assign dbg_rdata = dbg_rdata_q;
   assign illegal_access_reset = ill_q;
   assign irq = 1'b0;
endmodule : memory_map_paging_control
`default_nettype wire

// ==== mmap_monitor.sv ====
`default_nettype none
module mmap_monitor
   import mmap_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire mmap_pkg::bus_req_s cpu_req,
   input wire logic cpu_op_done,
   input wire logic cpu_stall,
   input wire logic [15:0] cpu_rdata,
   input wire mmap_pkg::bus_req_s dbg_req,
   input wire logic dbg_active,
   input wire logic dbg_grant,
   input wire logic far_call,
   input wire logic far_ret,
   input wire logic [3:0] far_page_new,
   input wire logic [3:0] far_page_saved,
   input wire logic far_busy,
   input wire mmap_pkg::tgt_req_s internal_target_bus,
   input wire logic [15:0] tgt_rdata,
   input wire logic tgt_ready,
   input wire logic [3:0] program_page_index,
   input wire logic irq
);
   logic [3:0] ret_page_q;
   logic [3:0] ret_page_d;
   logic [8:0] wait_q;
   logic [8:0] wait_d;
   // holding the pulled page avoids a deep past on a ranged check
   always_comb
   begin
      ret_page_d = far_ret ? far_page_new : ret_page_q;
      wait_d = (dbg_req.req && !dbg_grant) ? wait_q + 9'h001 : 9'h000;
   end
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ret_page_q <= 4'h0;
         wait_q <= 9'h000;
      end
      else
      begin
         ret_page_q <= ret_page_d;
         wait_q <= wait_d;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   sequence far_steps;
      far_busy [*3] ##1 !far_busy;
   endsequence
   sequence cpu_alone;
      cpu_req.req && !cpu_stall && !dbg_grant && !dbg_active && internal_target_bus.req;
   endsequence
   no_irq_a: assert property (irq == 1'b0)
      else $error("irq raised");
   window_map_a: assert property (cpu_alone and cpu_req.addr[15:14] == 2'b10
      |-> internal_target_bus.addr == {program_page_index, cpu_req.addr[13:0]})
      else $error("window address wrong");
   top_fixed_a: assert property (cpu_alone and cpu_req.addr[15:14] == 2'b11
      |-> internal_target_bus.addr == {PAGE_FIXED_TOP, cpu_req.addr[13:0]})
      else $error("top block address wrong");
   mid_fixed_a: assert property (cpu_alone and cpu_req.addr[15:14] == 2'b01
      |-> internal_target_bus.addr == {PAGE_FIXED_MID, cpu_req.addr[13:0]})
      else $error("middle block address wrong");
   far_call_a: assert property (far_call |=> (program_page_index == $past(far_page_new)
      && far_page_saved == $past(program_page_index)) ##0 far_steps)
      else $error("far call sequence wrong");
   far_ret_a: assert property (far_ret |-> ##[1:4] program_page_index == ret_page_q)
      else $error("far return page late");
   read_swap_a: assert property (cpu_alone and !cpu_req.wr && tgt_ready
      |=> cpu_rdata == {$past(tgt_rdata[7:0]), $past(tgt_rdata[15:8])})
      else $error("read data not swapped");
   cpu_first_a: assert property (cpu_req.req && dbg_req.req && !$past(dbg_grant)
      && wait_q < 9'd128 |-> !dbg_grant)
      else $error("debug won too early");
   debug_wins_a: assert property (wait_q > 9'd128 && cpu_op_done
      |-> ##[0:3] (dbg_grant && cpu_stall))
      else $error("stalled debug not granted");
endmodule : mmap_monitor
`default_nettype wire

// ==== target_model.sv ====
`default_nettype none
module target_model
   import mmap_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire mmap_pkg::tgt_req_s internal_target_bus,
   input wire logic slow,
   output logic [15:0] tgt_rdata,
   output logic tgt_ready
);
   logic [15:0] junk_q;
   logic ready_q;
   // slow mode answers every other cycle; junk moves so stale data never matches
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         junk_q <= 16'hA5C3;
         ready_q <= 1'b0;
      end
      else
      begin
         junk_q <= {junk_q[14:0], junk_q[15] ^ junk_q[13]};
         ready_q <= !ready_q;
      end
   end
   // one bus serves every resource, so data is a pure function of address
   assign tgt_ready = !slow || ready_q;
   assign tgt_rdata = (tgt_ready && internal_target_bus.req) ?
      {internal_target_bus.addr[7:0], internal_target_bus.addr[15:8]} ^ 16'h5A3C : junk_q;
endmodule : target_model
`default_nettype wire

// ==== memory_map_paging_control_test.sv ====
`default_nettype none
module memory_map_paging_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   import mmap_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0, slow = 1'b0;
   bus_req_s cpu_req = '0, dbg_req = '0;
   logic cpu_op_done = 1'b0, cpu_fw_cmd = 1'b0, cpu_single_chip = 1'b0;
   logic dbg_active = 1'b0, dbg_read_cycle = 1'b0, dbg_write_cycle = 1'b0;
   logic dbg_page_en = 1'b0, dbg_hw_cmd = 1'b0, far_call = 1'b0, far_ret = 1'b0;
   logic [3:0] debug_program_page_index = 4'h0, far_page_new = 4'h0, pg, cur;
   logic cpu_stall, dbg_grant, far_busy, illegal_access_reset, irq, tgt_ready;
   logic [15:0] cpu_rdata, dbg_rdata, tgt_rdata;
   logic [3:0] far_page_saved, program_page_index;
   tgt_req_s internal_target_bus;
   logic [31:0] seed = 32'h3EA2;
   int errors = 0, tests_run = 0, resets = 0, n;
   memory_map_paging_control i_dut
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .cpu_req(cpu_req),
      .cpu_op_done(cpu_op_done),
      .cpu_fw_cmd(cpu_fw_cmd),
      .cpu_single_chip(cpu_single_chip),
      .cpu_stall(cpu_stall),
      .cpu_rdata(cpu_rdata),
      .dbg_req(dbg_req),
      .dbg_active(dbg_active),
      .dbg_read_cycle(dbg_read_cycle),
      .dbg_write_cycle(dbg_write_cycle),
      .dbg_page_en(dbg_page_en),
      .dbg_hw_cmd(dbg_hw_cmd),
      .debug_program_page_index(debug_program_page_index),
      .dbg_grant(dbg_grant),
      .dbg_rdata(dbg_rdata),
      .far_call(far_call),
      .far_ret(far_ret),
      .far_page_new(far_page_new),
      .far_page_saved(far_page_saved),
      .far_busy(far_busy),
      .internal_target_bus(internal_target_bus),
      .tgt_rdata(tgt_rdata),
      .tgt_ready(tgt_ready),
      .program_page_index(program_page_index),
      .illegal_access_reset(illegal_access_reset),
      .irq(irq)
   );
   target_model i_tgt
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .internal_target_bus(internal_target_bus),
      .slow(slow),
      .tgt_rdata(tgt_rdata),
      .tgt_ready(tgt_ready)
   );
   always #20 ref_clk = ~ref_clk;
   // count reset pulses; one driver only, the checks compare counts
   always @(posedge ref_clk)
      if (illegal_access_reset === 1'b1)
         resets <= resets + 1;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic bus_req_s rd(input logic [15:0] a);
      return '{1'b1, 1'b0, 1'b1, a, 16'h0000};
   endfunction : rd
   // word the partner returns for an address
   function automatic logic [15:0] tgt_word(input logic [17:0] a);
      return {a[7:0], a[15:8]} ^ 16'h5A3C;
   endfunction : tgt_word
   // the processor sees every target word with its bytes exchanged
   function automatic logic [15:0] swab(input logic [15:0] w);
      return {w[7:0], w[15:8]};
   endfunction : swab
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input bus_req_s c, input bus_req_s d);
      @(posedge ref_clk);
      cpu_req <= c;
      dbg_req <= d;
      @(negedge ref_clk);
   endtask : step
   task automatic far_op(input logic ret, input logic [3:0] p);
      @(posedge ref_clk);
      far_call <= !ret;
      far_ret <= ret;
      far_page_new <= p;
      @(posedge ref_clk);
      far_call <= 1'b0;
      far_ret <= 1'b0;
      repeat (5) @(negedge ref_clk);
   endtask : far_op
   task automatic give_verdict;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      give_verdict;
   end
   initial
   begin
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(negedge ref_clk);
      chk(program_page_index, PAGE_RESET);
      // plain memory write, then read back of the page index
      step('{1'b1, 1'b1, 1'b0, PAGE_REG_ADDR, 16'h0007}, '0);
      step(rd(PAGE_REG_ADDR), '0);
      chk(program_page_index, 4'h7);
      @(negedge ref_clk);
      chk(cpu_rdata, 16'h0007);
      cur = 4'h7;
      // random pages kept off the low pages 0 and 1; a hole in page 0 is tried below
      for (int i = 0; i < 40; i++)
      begin
         seed = lfsr(seed);
         pg = (seed[3:0] < 4'h2) ? seed[3:0] + 4'h2 : seed[3:0];
         far_op(1'b0, pg);
         chk(far_page_saved, cur);
         chk(program_page_index, pg);
         cur = pg;
         step(rd({2'b10, seed[29:16]}), '0);
         chk(internal_target_bus.addr, {pg, seed[29:16]});
         step(rd({2'b11, seed[29:16]}), '0);
         chk(internal_target_bus.addr, {PAGE_FIXED_TOP, seed[29:16]});
         // read data is registered, so it shows one edge later
         @(negedge ref_clk);
         chk(cpu_rdata, swab(tgt_word({PAGE_FIXED_TOP, seed[29:16]})));
         step('{1'b1, 1'b1, 1'b0, {2'b01, seed[29:16]}, seed[15:0]}, '0);
         chk(internal_target_bus.addr, {PAGE_FIXED_MID, seed[29:16]});
         chk(internal_target_bus.wdata, seed[15:0]);
      end
      far_op(1'b1, 4'hF);
      chk(program_page_index, 4'hF);
      @(posedge ref_clk);
      dbg_active <= 1'b1;
      dbg_read_cycle <= 1'b1;
      // outside the debug range the debug cycle, or with page 0x0F the 0xBF00 alias, selects debug resources
      step('0, rd(16'h1010));
      chk(internal_target_bus.dbg_sel, 1'b1);
      step(rd(16'hBF10), '0);
      chk(internal_target_bus.dbg_sel, 1'b1);
      step(rd(16'hFF20), '0);
      chk(internal_target_bus.dbg_sel, 1'b1);
      @(posedge ref_clk);
      dbg_read_cycle <= 1'b0;
      dbg_write_cycle <= 1'b1;
      step('0, '{1'b1, 1'b1, 1'b1, 16'h1012, 16'h1234});
      chk(internal_target_bus.dbg_sel, 1'b1);
      chk(internal_target_bus.wdata, 16'h1234);
      @(posedge ref_clk);
      dbg_active <= 1'b0;
      dbg_write_cycle <= 1'b0;
      dbg_page_en <= 1'b1;
      dbg_hw_cmd <= 1'b1;
      debug_program_page_index <= 4'h5;
      step('0, rd(16'h8122));
      chk(internal_target_bus.dbg_sel, 1'b0);
      chk(internal_target_bus.addr, 18'h14122);
      @(posedge ref_clk);
      dbg_page_en <= 1'b0;
      cpu_single_chip <= 1'b1;
      step('0, rd(16'h8122));
      chk(internal_target_bus.addr, 18'h3C122);
      @(negedge ref_clk);
      chk(dbg_rdata, tgt_word(18'h3C122));
      far_op(1'b0, 4'h0);
      step('0, rd(16'h8400));
      step('0, '0);
      chk(resets, 0);
      chk(dbg_rdata, 16'h0000);
      step(rd(16'h8400), '0);
      step('0, '0);
      step('0, '0);
      chk(resets, 1);
      @(posedge ref_clk);
      cpu_fw_cmd <= 1'b1;
      step(rd(16'h8400), '0);
      step('0, '0);
      step('0, '0);
      chk(resets, 1);
      @(posedge ref_clk);
      slow <= 1'b1;
      step(rd(16'hC000), rd(16'hC002));
      chk(dbg_grant, 1'b0);
      chk(cpu_stall, 1'b0);
      repeat (130) @(posedge ref_clk);
      cpu_op_done <= 1'b1;
      n = 0;
      while (dbg_grant !== 1'b1 && n < 8)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk(cpu_stall, 1'b1);
      chk(dbg_grant, 1'b1);
      chk(irq, 1'b0);
      give_verdict;
   end
endmodule : memory_map_paging_control_test
bind memory_map_paging_control mmap_monitor i_mon
(
   .ref_clk(ref_clk),
   .arst_n(arst_n),
   .cpu_req(cpu_req),
   .cpu_op_done(cpu_op_done),
   .cpu_stall(cpu_stall),
   .cpu_rdata(cpu_rdata),
   .dbg_req(dbg_req),
   .dbg_active(dbg_active),
   .dbg_grant(dbg_grant),
   .far_call(far_call),
   .far_ret(far_ret),
   .far_page_new(far_page_new),
   .far_page_saved(far_page_saved),
   .far_busy(far_busy),
   .internal_target_bus(internal_target_bus),
   .tgt_rdata(tgt_rdata),
   .tgt_ready(tgt_ready),
   .program_page_index(program_page_index),
   .irq(irq)
);
`default_nettype wire
